/* File: design/meter_status_defines.vh */
`ifndef METER_STATUS_DEFINES_VH
`define METER_STATUS_DEFINES_VH

// ----------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------
`define IDX_VOLTAGE_PEAK_CAPTURE 16'hE501
`define IDX_EVENT_STATUS_PRIMARY 16'hE502
`define IDX_MEASURE_MODE 16'hE504
`define IDX_PULSE_MODE 16'hE505
`define IDX_POWER_SIGN 16'hE506
`define IDX_FORMAT_SAMPLE 16'hE507
`define IDX_FORMAT_SIGNED 16'hE508
`define IDX_FORMAT_SHORT 16'hE509
`define IDX_SHIFT 2
`define ADDR_LOW_BITS 2'h0

// ----------------------------------------------------------------
// field layouts
// ----------------------------------------------------------------
`define PEAK_MAG_MSB 23
`define PEAK_PHASE_LSB 24
`define PEAK_PHASE_MSB 26
`define STATUS_MSB 18
`define ST_TOTAL_ACTIVE_HF 0
`define ST_FUND_ACTIVE_HF 1
`define ST_TOTAL_REACTIVE_HF 2
`define ST_FUND_REACTIVE_HF 3
`define ST_APPARENT_HF 4
`define ST_LINE_CYCLE_DONE 5
`define ST_ACTIVE_FLIP_LSB 6
`define ST_SUM1_FLIP 9
`define ST_REACTIVE_FLIP_LSB 10
`define ST_SUM2_FLIP 13
`define ST_PULSE_LSB 14
`define ST_DSP_DONE 17
`define ST_SUM3_FLIP 18
`define MM_ACTIVE_SEL 0
`define MM_REACTIVE_SEL 1
`define MM_MSB 1
`define PM_MSB 11
`define PM_DISABLE_LSB 9
`define PM_SOURCE_W 3
`define PS_ACTIVE_LSB 0
`define PS_SUM1 3
`define PS_REACTIVE_LSB 4
`define PS_SUM2 7
`define PS_SUM3 8
`define PS_MSB 8
`define SHORT_MSB 9

// ----------------------------------------------------------------
// reset values and bus codes
// ----------------------------------------------------------------
`define RST_WORD 32'h00000000
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'h0

`endif

/* File: design/meter_peak_and_event_status.v */
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`include "meter_status_defines.vh"

module meter_peak_and_event_status (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire peak_update,
  input wire [23:0] peak_magnitude,
  input wire [2:0] peak_source_phase,
  input wire [2:0] total_active_bit30,
  input wire [2:0] fund_active_bit30,
  input wire [2:0] total_reactive_bit30,
  input wire [2:0] fund_reactive_bit30,
  input wire [2:0] apparent_bit30,
  input wire line_cycle_end,
  input wire [2:0] total_active_sign,
  input wire [2:0] fund_active_sign,
  input wire [2:0] total_reactive_sign,
  input wire [2:0] fund_reactive_sign,
  input wire [2:0] sum_sign,
  input wire [2:0] pulse_raw,
  input wire dsp_cycle_end,
  output wire active_sign_source_sel,
  output wire reactive_sign_source_sel,
  output reg pulse_out_1,
  output reg pulse_out_2,
  output reg pulse_out_3,
  output wire [2:0] pulse_out_1_source,
  output wire [2:0] pulse_out_2_source,
  output wire [2:0] pulse_out_3_source
);

  // ----------------------------------------------------------------
  // output formatting and address helpers
  // ----------------------------------------------------------------
  function [31:0] pad24;
    input [23:0] v;
    begin
      pad24 = {8'h00, v};
    end
  endfunction

  function [31:0] sext24;
    input [23:0] v;
    begin
      sext24 = {{8{v[23]}}, v};
    end
  endfunction

  function [15:0] pad10;
    input [9:0] v;
    begin
      pad10 = {6'h00, v};
    end
  endfunction

  function [31:0] word_addr;
    input [15:0] idx;
    begin
      word_addr = {14'h0000, idx, `ADDR_LOW_BITS};
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [23:0] peak_mag_reg;
  reg [2:0] peak_phase_reg;
  reg [`STATUS_MSB:0] status_reg;
  reg [`STATUS_MSB:0] status_next;
  reg [`STATUS_MSB:0] status_set;
  reg [`MM_MSB:0] measure_mode_reg;
  reg [`PM_MSB:0] pulse_mode_reg;
  reg [`PS_MSB:0] power_sign_reg;
  reg [23:0] format_sample_reg;
  reg [2:0] ta30_reg;
  reg [2:0] fa30_reg;
  reg [2:0] tr30_reg;
  reg [2:0] fr30_reg;
  reg [2:0] ap30_reg;
  reg [2:0] pulse_prev_reg;
  reg wr_pend_reg;
  reg [31:0] wr_addr_reg;
  reg [`PS_MSB:0] sign_now;
  wire addr_phase;
  wire [2:0] pulse_fall;

  assign hreadyout = 1'b1;
  assign hresp = `HRESP_OKAY;
  assign addr_phase = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];

  assign active_sign_source_sel = measure_mode_reg[`MM_ACTIVE_SEL];
  assign reactive_sign_source_sel = measure_mode_reg[`MM_REACTIVE_SEL];
  assign pulse_out_1_source = pulse_mode_reg[`PM_SOURCE_W-1:0];
  assign pulse_out_2_source = pulse_mode_reg[2*`PM_SOURCE_W-1:`PM_SOURCE_W];
  assign pulse_out_3_source = pulse_mode_reg[3*`PM_SOURCE_W-1:2*`PM_SOURCE_W];

  // ----------------------------------------------------------------
  // pulse outputs
  // ----------------------------------------------------------------
  // edges are taken from the raw pulse, so a disabled pin still flags
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : pulse_edge
      assign pulse_fall[g] = pulse_prev_reg[g] & ~pulse_raw[g];
    end
  endgenerate

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_out_1 <= 1'b1;
      pulse_out_2 <= 1'b1;
      pulse_out_3 <= 1'b1;
    end else begin
      // idle level is high, so a disabled output parks high
      pulse_out_1 <= pulse_raw[0] | pulse_mode_reg[`PM_DISABLE_LSB];
      pulse_out_2 <= pulse_raw[1] | pulse_mode_reg[`PM_DISABLE_LSB+1];
      pulse_out_3 <= pulse_raw[2] | pulse_mode_reg[`PM_DISABLE_LSB+2];
    end
  end

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  always @* begin
    sign_now = power_sign_reg;
    sign_now[`PS_ACTIVE_LSB+2:`PS_ACTIVE_LSB] = measure_mode_reg[`MM_ACTIVE_SEL] ?
      fund_active_sign : total_active_sign;
    sign_now[`PS_REACTIVE_LSB+2:`PS_REACTIVE_LSB] = measure_mode_reg[`MM_REACTIVE_SEL] ?
      fund_reactive_sign : total_reactive_sign;
    sign_now[`PS_SUM1] = sum_sign[0];
    sign_now[`PS_SUM2] = sum_sign[1];
    sign_now[`PS_SUM3] = sum_sign[2];
  end

  always @* begin
    status_set = {(`STATUS_MSB+1){1'b0}};
    status_set[`ST_TOTAL_ACTIVE_HF] = |(ta30_reg ^ total_active_bit30);
    status_set[`ST_FUND_ACTIVE_HF] = |(fa30_reg ^ fund_active_bit30);
    status_set[`ST_TOTAL_REACTIVE_HF] = |(tr30_reg ^ total_reactive_bit30);
    status_set[`ST_FUND_REACTIVE_HF] = |(fr30_reg ^ fund_reactive_bit30);
    status_set[`ST_APPARENT_HF] = |(ap30_reg ^ apparent_bit30);
    status_set[`ST_LINE_CYCLE_DONE] = line_cycle_end;
    status_set[`ST_ACTIVE_FLIP_LSB+2:`ST_ACTIVE_FLIP_LSB] =
      sign_now[`PS_ACTIVE_LSB+2:`PS_ACTIVE_LSB] ^
      power_sign_reg[`PS_ACTIVE_LSB+2:`PS_ACTIVE_LSB];
    status_set[`ST_REACTIVE_FLIP_LSB+2:`ST_REACTIVE_FLIP_LSB] =
      sign_now[`PS_REACTIVE_LSB+2:`PS_REACTIVE_LSB] ^
      power_sign_reg[`PS_REACTIVE_LSB+2:`PS_REACTIVE_LSB];
    status_set[`ST_SUM1_FLIP] = sign_now[`PS_SUM1] ^ power_sign_reg[`PS_SUM1];
    status_set[`ST_SUM2_FLIP] = sign_now[`PS_SUM2] ^ power_sign_reg[`PS_SUM2];
    status_set[`ST_SUM3_FLIP] = sign_now[`PS_SUM3] ^ power_sign_reg[`PS_SUM3];
    status_set[`ST_PULSE_LSB+2:`ST_PULSE_LSB] = pulse_fall;
    status_set[`ST_DSP_DONE] = dsp_cycle_end;
  end

  // set wins over a clear landing in the same cycle
  always @* begin
    status_next = status_reg;
    if (wr_pend_reg && wr_addr_reg == word_addr(`IDX_EVENT_STATUS_PRIMARY)) begin
      status_next = status_reg & ~hwdata[`STATUS_MSB:0];
    end
    status_next = status_next | status_set;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      peak_mag_reg <= 24'h000000;
      peak_phase_reg <= 3'h0;
      status_reg <= {(`STATUS_MSB+1){1'b0}};
      measure_mode_reg <= {(`MM_MSB+1){1'b0}};
      pulse_mode_reg <= {(`PM_MSB+1){1'b0}};
      power_sign_reg <= {(`PS_MSB+1){1'b0}};
      format_sample_reg <= 24'h000000;
      ta30_reg <= 3'h0;
      fa30_reg <= 3'h0;
      tr30_reg <= 3'h0;
      fr30_reg <= 3'h0;
      ap30_reg <= 3'h0;
      pulse_prev_reg <= 3'h7;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= `RST_WORD;
    end else begin
      if (peak_update) begin
        peak_mag_reg <= peak_magnitude;
        peak_phase_reg <= peak_source_phase;
      end
      status_reg <= status_next;
      power_sign_reg <= sign_now;
      ta30_reg <= total_active_bit30;
      fa30_reg <= fund_active_bit30;
      tr30_reg <= total_reactive_bit30;
      fr30_reg <= fund_reactive_bit30;
      ap30_reg <= apparent_bit30;
      pulse_prev_reg <= pulse_raw;
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_reg <= haddr;
      end
      if (wr_pend_reg) begin
        if (wr_addr_reg == word_addr(`IDX_MEASURE_MODE)) begin
          measure_mode_reg <= hwdata[`MM_MSB:0];
        end
        if (wr_addr_reg == word_addr(`IDX_PULSE_MODE)) begin
          pulse_mode_reg <= hwdata[`PM_MSB:0];
        end
        if (wr_addr_reg == word_addr(`IDX_FORMAT_SAMPLE)) begin
          format_sample_reg <= hwdata[23:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // read data is latched at the address phase, so a clear written in
  // the previous data phase may still show in a back-to-back read
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `RST_WORD;
    end else if (addr_phase && !hwrite) begin
      case (haddr)
        word_addr(`IDX_VOLTAGE_PEAK_CAPTURE): begin
          hrdata <= {5'h00, peak_phase_reg, peak_mag_reg};
        end
        word_addr(`IDX_EVENT_STATUS_PRIMARY): begin
          hrdata <= {13'h0000, status_reg};
        end
        word_addr(`IDX_MEASURE_MODE): begin
          hrdata <= {30'h00000000, measure_mode_reg};
        end
        word_addr(`IDX_PULSE_MODE): begin
          hrdata <= {20'h00000, pulse_mode_reg};
        end
        word_addr(`IDX_POWER_SIGN): begin
          hrdata <= {23'h000000, power_sign_reg};
        end
        word_addr(`IDX_FORMAT_SAMPLE): begin
          hrdata <= pad24(format_sample_reg);
        end
        word_addr(`IDX_FORMAT_SIGNED): begin
          hrdata <= sext24(format_sample_reg);
        end
        word_addr(`IDX_FORMAT_SHORT): begin
          hrdata <= {16'h0000, pad10(format_sample_reg[`SHORT_MSB:0])};
        end
        default: begin
          hrdata <= `RST_WORD;
        end
      endcase
    end
  end

endmodule // meter_peak_and_event_status

/* File: test/status_props.sv */
`timescale 1ns/1ps
`include "meter_status_defines.vh"
// ----------------------------------------------------------------
// read field, pulse output and mode select checks
// ----------------------------------------------------------------
module status_props (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire [2:0] pulse_raw,
  input wire pulse_out_1,
  input wire pulse_out_2,
  input wire [2:0] pulse_out_1_source,
  input wire active_sign_source_sel
);
  reg rd_reg;
  reg wr_reg;
  reg [15:0] idx_reg;
  // data phase follows the taken address phase, so remember it for one cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      idx_reg <= 16'h0000;
    end else begin
      rd_reg <= hsel & hready & htrans[1] & !hwrite;
      wr_reg <= hsel & hready & htrans[1] & hwrite;
      idx_reg <= haddr[17:2];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_peak_top_zero: assert property (rd_reg && idx_reg == `IDX_VOLTAGE_PEAK_CAPTURE
    |-> hrdata[31:27] == 5'h00) else $error("peak upper bits set");
  a_status_top_zero: assert property (rd_reg && idx_reg == `IDX_EVENT_STATUS_PRIMARY
    |-> hrdata[31:19] == 13'h0000) else $error("status upper bits set");
  a_pad_top_zero: assert property (rd_reg && idx_reg == `IDX_FORMAT_SAMPLE
    |-> hrdata[31:24] == 8'h00) else $error("padded word top not zero");
  a_sign_ext_top: assert property (rd_reg && idx_reg == `IDX_FORMAT_SIGNED
    |-> hrdata[31:24] == {8{hrdata[23]}}) else $error("sign extension wrong");
  a_short_top_zero: assert property (rd_reg && idx_reg == `IDX_FORMAT_SHORT
    |-> hrdata[31:10] == 22'h000000) else $error("short word top not zero");
  a_pulse1_follow: assert property (!pulse_out_1 |-> !$past(pulse_raw[0]))
    else $error("pulse 1 low without raw pulse");
  a_pulse2_follow: assert property (!pulse_out_2 |-> !$past(pulse_raw[1]))
    else $error("pulse 2 low without raw pulse");
  a_source_hold: assert property ($changed(pulse_out_1_source)
    |-> $past(wr_reg && idx_reg == `IDX_PULSE_MODE)) else $error("source moved unwritten");
  a_select_hold: assert property ($changed(active_sign_source_sel)
    |-> $past(wr_reg && idx_reg == `IDX_MEASURE_MODE)) else $error("select moved unwritten");
  c_status_read: cover property (rd_reg && idx_reg == `IDX_EVENT_STATUS_PRIMARY);
  c_pulse_low: cover property (!pulse_out_1);
  c_source_move: cover property ($changed(pulse_out_1_source));
endmodule // status_props

bind meter_peak_and_event_status status_props status_props_i (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hrdata, .pulse_raw, .pulse_out_1, .pulse_out_2,
  .pulse_out_1_source, .active_sign_source_sel);

/* File: test/ahb_host.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host side: single word ahb-lite transfers
// ----------------------------------------------------------------
module ahb_host (
  input wire hclk,
  input wire hready,
  input wire [31:0] hrdata,
  output reg hsel = 1'b0,
  output reg [31:0] haddr = 32'h00000000,
  output reg [1:0] htrans = 2'h0,
  output reg hwrite = 1'b0,
  output reg [2:0] hsize = 3'h2,
  output reg [31:0] hwdata = 32'h00000000
);
  // caller enters just after a rising edge; nothing assumes zero wait states
  task xfer(input w, input [15:0] idx, input [31:0] wd, output [31:0] rd);
    begin
      hsel <= 1'b1;
      haddr <= {14'h0000, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      hwdata <= ~wd;
    end
  endtask
endmodule // ahb_host

/* File: test/meter_peak_and_event_status_tb.sv */
`timescale 1ns/1ps
`include "meter_status_defines.vh"
module meter_peak_and_event_status_tb;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg [28:0] ev = 29'h0E000000;
  reg [5:0] fs = 6'h00;
  reg [1:0] mm;
  reg [2:0] pm;
  reg [27:0] pk_in = 28'h0000000;
  reg [28:0] pe;
  reg [18:0] st;
  reg [8:0] sg;
  reg [31:0] pk;
  reg [31:0] d;
  reg [31:0] rdv;
  reg wr_ph;
  reg [15:0] wr_idx;
  integer seed = 32'ha77fff36;
  integer bad_count = 0;
  integer checked = 0;
  integer i;
  integer n;
  wire hsel, hwrite, hready, hresp, asel, rsel, po1, po2, po3;
  wire [1:0] htrans;
  wire [2:0] hsize, src1, src2, src3;
  wire [31:0] haddr, hwdata, hrdata;
  wire [8:0] nsg = {ev[24:23], mm[1] ? fs[5:3] : ev[21:19], ev[22],
    mm[0] ? fs[2:0] : ev[18:16]};
  wire [8:0] x = sg ^ nsg;
  wire [18:0] set = {x[8], ev[28], pe[27:25] & ~ev[27:25], x[7:0], ev[15],
    |(pe[14:12] ^ ev[14:12]), |(pe[11:9] ^ ev[11:9]), |(pe[8:6] ^ ev[8:6]),
    |(pe[5:3] ^ ev[5:3]), |(pe[2:0] ^ ev[2:0])};
  ahb_host ahb_host_i (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  meter_peak_and_event_status meter_peak_and_event_status_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .peak_update(pk_in[27]), .peak_magnitude(pk_in[23:0]), .peak_source_phase(pk_in[26:24]),
    .total_active_bit30(ev[2:0]), .fund_active_bit30(ev[5:3]),
    .total_reactive_bit30(ev[8:6]), .fund_reactive_bit30(ev[11:9]),
    .apparent_bit30(ev[14:12]), .line_cycle_end(ev[15]), .total_active_sign(ev[18:16]),
    .fund_active_sign(fs[2:0]), .total_reactive_sign(ev[21:19]),
    .fund_reactive_sign(fs[5:3]), .sum_sign(ev[24:22]), .pulse_raw(ev[27:25]),
    .dsp_cycle_end(ev[28]), .active_sign_source_sel(asel), .reactive_sign_source_sel(rsel),
    .pulse_out_1(po1), .pulse_out_2(po2), .pulse_out_3(po3), .pulse_out_1_source(src1),
    .pulse_out_2_source(src2), .pulse_out_3_source(src3));
  // model: selection follows the measure mode word as the host writes it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= 19'h00000;
      sg <= 9'h000;
      pe <= 29'h0E000000;
      pk <= 32'h00000000;
      wr_ph <= 1'b0;
      wr_idx <= 16'h0000;
      mm <= 2'h0;
      pm <= 3'h0;
    end else begin
      if (wr_ph && wr_idx == `IDX_MEASURE_MODE) mm <= hwdata[1:0];
      if (wr_ph && wr_idx == `IDX_PULSE_MODE) pm <= hwdata[11:9];
      st <= (wr_ph && wr_idx == `IDX_EVENT_STATUS_PRIMARY) ? (st & ~hwdata[18:0]) | set : st | set;
      sg <= nsg;
      pe <= ev;
      if (pk_in[27]) pk <= {5'h00, pk_in[26:0]};
      wr_ph <= hsel & hready & htrans[1] & hwrite;
      wr_idx <= haddr[17:2];
    end
  end
  task chk(input [31:0] e, input [31:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
    end
  endtask
  // the clear already lands at the data phase edge inside xfer; the extra edge only adds an idle cycle
  task wr(input [15:0] idx, input [31:0] v);
    begin
      ahb_host_i.xfer(1'b1, idx, v, rdv);
      @(posedge hclk);
    end
  endtask
  task rd_chk(input [15:0] idx, input [31:0] e);
    begin
      ahb_host_i.xfer(1'b0, idx, 32'h00000000, rdv);
      chk(e, rdv);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    forever #2 hclk = ~hclk;
  end
  initial begin
    #80000;
    bad_count = bad_count + 1;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(`IDX_VOLTAGE_PEAK_CAPTURE, 32'h00000000);
    rd_chk(`IDX_EVENT_STATUS_PRIMARY, {13'h0000, st});
    wr(16'hE50F, 32'hFFFFFFFF);
    rd_chk(16'hE50F, 32'h00000000);
    $display("test reset done");
    for (n = 0; n < 4; n = n + 1) begin
      d = $random(seed);
      wr(`IDX_MEASURE_MODE, d);
      wr(`IDX_PULSE_MODE, d);
      chk({21'h000000, d[1:0], d[8:0]}, {21'h000000, rsel, asel, src3, src2, src1});
      for (i = 0; i < 20; i = i + 1) begin
        @(posedge hclk);
        d = $random(seed);
        ev <= $random(seed);
        fs <= $random(seed);
        pk_in <= {d[31], 3'h1 << (d[30:29] % 3), d[23:0]};
      end
      @(posedge hclk);
      ev[15] <= 1'b0;
      ev[28] <= 1'b0;
      pk_in[27] <= 1'b0;
      repeat (2) @(posedge hclk);
      chk({29'h00000000, ev[27:25] | pm}, {29'h00000000, po3, po2, po1});
      rd_chk(`IDX_EVENT_STATUS_PRIMARY, {13'h0000, st});
      rd_chk(`IDX_POWER_SIGN, {23'h000000, sg});
      rd_chk(`IDX_VOLTAGE_PEAK_CAPTURE, pk);
      wr(`IDX_EVENT_STATUS_PRIMARY, $random(seed));
      rd_chk(`IDX_EVENT_STATUS_PRIMARY, {13'h0000, st});
      $display("test events %0d done", n);
    end
    d = $random(seed);
    wr(`IDX_FORMAT_SAMPLE, d);
    rd_chk(`IDX_FORMAT_SAMPLE, {8'h00, d[23:0]});
    rd_chk(`IDX_FORMAT_SIGNED, {{8{d[23]}}, d[23:0]});
    rd_chk(`IDX_FORMAT_SHORT, {22'h000000, d[9:0]});
    $display("test formats done");
    end_sim;
  end
endmodule // meter_peak_and_event_status_tb
